/* File: rtl/dwp_datapath.sv */
// Drum word parity datapath with its AXI4-Lite register slave.
//
// Added by the designer: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
module dwp_datapath
	import dwp_pkg::*;
(
	// Clock and reset.
	input  wire logic              mclk_i,
	input  wire logic              reset_i,
	// Drum timing generator enables, same clock domain.
	input  wire logic              phase1_i,
	input  wire logic              phase2_i,
	input  wire logic              phase3_i,
	input  wire logic              phase4_i,
	input  wire logic              read_strobe_i,
	input  wire logic              write_go_i,
	// Memory control via pulsed bus transceiver (external pins).
	input  wire logic [DATA_W-1:0] bus_in_i,
	input  wire logic              addr_ack_i,
	input  wire logic              write_restart_i,
	input  wire logic              read_restart_i,
	output logic [DATA_W-1:0]      bus_out_o,
	// Sense amplifiers, bit 18 is the parity sense pulse (pins).
	input  wire logic [WORD_W-1:0] sense_i,
	// Maintenance button and power clear (pins).
	input  wire logic              bad_parity_button_i,
	input  wire logic              power_clear_i,
	// Data writers.
	output logic [WORD_W-1:0]      writer_one_o,
	output logic [WORD_W-1:0]      writer_zero_o,
	output logic                   write_enable_o,
	// Error flag level.
	output logic                   parity_mismatch_flag_o,
	// AXI4-Lite slave.
	input  wire logic [3:0]        s_axi_awaddr_i,
	input  wire logic              s_axi_awvalid_i,
	output logic                   s_axi_awready_o,
	input  wire logic [31:0]       s_axi_wdata_i,
	input  wire logic [3:0]        s_axi_wstrb_i,
	input  wire logic              s_axi_wvalid_i,
	output logic                   s_axi_wready_o,
	output logic [1:0]             s_axi_bresp_o,
	output logic                   s_axi_bvalid_o,
	input  wire logic              s_axi_bready_i,
	input  wire logic [3:0]        s_axi_araddr_i,
	input  wire logic              s_axi_arvalid_i,
	output logic                   s_axi_arready_o,
	output logic [31:0]            s_axi_rdata_o,
	output logic [1:0]             s_axi_rresp_o,
	output logic                   s_axi_rvalid_o,
	input  wire logic              s_axi_rready_i
);

	localparam int SYNC_W = DATA_W + WORD_W + 5;

	// True when the word holds an even number of ones.
	function automatic logic even_ones(input logic [DATA_W-1:0] w);
		even_ones = ~(^w);
	endfunction

	// Software registers and datapath state.
	logic [CTRL_W-1:0]  ctrl;
	logic [DATA_W-1:0]  inbound_word_hold;
	logic [DATA_W-1:0]  outbound_word_hold;
	logic               read_parity;
	logic               force_bad;
	logic               parity_mismatch_flag;
	logic               write_strobe;

	// Synchroniser stages for all pin inputs.
	logic [SYNC_W-1:0]  sync_a;
	logic [SYNC_W-1:0]  sync_b;
	logic [DATA_W-1:0]  s_bus;
	logic [WORD_W-1:0]  s_sense;
	logic               s_ack;
	logic               s_wrestart;
	logic               s_rrestart;
	logic               s_button;
	logic               s_pclear;

	// Derived levels.
	logic               drum_active;
	logic               write_mode;
	logic               read_ctrl;
	logic               write_only;
	logic               write_allow;
	logic               write_even;
	logic               parity_bit;
	logic               mismatch;
	logic               err_set;
	logic               err_clear;

	// Bus slave state.
	logic               aw_held;
	logic               w_held;
	logic [3:0]         aw_addr;
	logic [31:0]        w_data;
	logic [3:0]         w_strb;
	logic               do_write;
	logic [31:0]        next_rdata;
	logic [1:0]         next_rresp;

	// Two flip-flops on every pin input; only the second stage is read.
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			sync_a <= '0;
			sync_b <= '0;
		end else begin
			sync_a <= {bus_in_i, sense_i, addr_ack_i, write_restart_i,
				read_restart_i, bad_parity_button_i, power_clear_i};
			sync_b <= sync_a;
		end
	end

	assign {s_bus, s_sense, s_ack, s_wrestart, s_rrestart, s_button,
		s_pclear} = sync_b;

	assign drum_active = ctrl[CTRL_ACTIVE];
	assign write_mode  = ctrl[CTRL_WRITE];
	assign read_ctrl   = ctrl[CTRL_READ];
	assign write_only  = ctrl[CTRL_WONLY];
	assign write_allow = drum_active && write_mode;

	// Write parity follows the in buffer continuously.
	assign write_even = even_ones(inbound_word_hold);
	assign parity_bit = write_even ^ force_bad;

	// Mismatch against the read parity bit, qualified for reads only.
	assign mismatch = (write_even && !read_parity) ||
		(!write_even && read_parity);
	assign err_set = phase4_i && mismatch && drum_active && read_ctrl &&
		!write_only;

	// Strobe timer for the data writers.
	dwp_strobe_timer u_strobe (
		.mclk_i   (mclk_i),
		.reset_i  (reset_i),
		.go_i     (write_go_i),
		.allow_i  (write_allow),
		.strobe_o (write_strobe)
	);

	// In buffer: loaded from the bus at address acknowledge, cleared at
	// phase 2 once the word has been written.
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			inbound_word_hold <= '0;
		end else if (s_ack) begin
			inbound_word_hold <= s_bus;
		end else if (phase2_i) begin
			inbound_word_hold <= '0;
		end
	end

	// Out buffer: cleared at acknowledge, then set from the in buffer in
	// write-only transfers or from the sense amplifiers otherwise.
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			outbound_word_hold <= '0;
		end else if (s_ack) begin
			outbound_word_hold <= '0;
		end else if (phase1_i && write_only) begin
			outbound_word_hold <= outbound_word_hold |
				inbound_word_hold;
		end else if (read_strobe_i && !write_only) begin
			outbound_word_hold <= outbound_word_hold |
				s_sense[DATA_W-1:0];
		end
	end

	// Out buffer pulsed onto the bus at phase 3.
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			bus_out_o <= '0;
		end else if (phase3_i) begin
			bus_out_o <= outbound_word_hold;
		end else begin
			bus_out_o <= '0;
		end
	end

	// Read parity flip-flop; a set in the restart cycle wins.
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			read_parity <= 1'b0;
		end else if (read_strobe_i && !write_only && s_sense[PAR_POS]) begin
			read_parity <= 1'b1;
		end else if (s_rrestart) begin
			read_parity <= 1'b0;
		end
	end

	// Force-bad-parity flip-flop; the button wins over a clear.
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			force_bad <= 1'b0;
		end else if (s_button) begin
			force_bad <= 1'b1;
		end else if (s_pclear || s_wrestart) begin
			force_bad <= 1'b0;
		end
	end

	// Parity error flag; software clears with a one, a set wins.
	assign err_clear = do_write && aw_addr == ADDR_STATUS && w_strb[0] &&
		w_data[STAT_PERR];

	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			parity_mismatch_flag <= 1'b0;
		end else if (err_set) begin
			parity_mismatch_flag <= 1'b1;
		end else if (err_clear) begin
			parity_mismatch_flag <= 1'b0;
		end
	end

	assign parity_mismatch_flag_o = parity_mismatch_flag;

	// Writer drive: gated bit and its inverse, both under write enable.
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			writer_one_o   <= '0;
			writer_zero_o  <= '0;
			write_enable_o <= 1'b0;
		end else begin
			write_enable_o <= write_allow;
			if (write_allow) begin
				writer_one_o  <= {parity_bit, inbound_word_hold} &
					{WORD_W{write_strobe}};
				writer_zero_o <= ~({parity_bit, inbound_word_hold} &
					{WORD_W{write_strobe}});
			end else begin
				writer_one_o  <= '0;
				writer_zero_o <= '0;
			end
		end
	end

	// Write address and data are taken independently and held.
	assign s_axi_awready_o = !aw_held && !s_axi_bvalid_o;
	assign s_axi_wready_o  = !w_held && !s_axi_bvalid_o;
	assign do_write        = aw_held && w_held && !s_axi_bvalid_o;

	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			aw_held <= 1'b0;
			aw_addr <= 4'h0;
		end else if (s_axi_awvalid_i && s_axi_awready_o) begin
			aw_held <= 1'b1;
			aw_addr <= s_axi_awaddr_i;
		end else if (do_write) begin
			aw_held <= 1'b0;
		end
	end

	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			w_held <= 1'b0;
			w_data <= 32'h0;
			w_strb <= 4'h0;
		end else if (s_axi_wvalid_i && s_axi_wready_o) begin
			w_held <= 1'b1;
			w_data <= s_axi_wdata_i;
			w_strb <= s_axi_wstrb_i;
		end else if (do_write) begin
			w_held <= 1'b0;
		end
	end

	// Write response, error for anything outside the map.
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o  <= RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid_o <= 1'b1;
			s_axi_bresp_o  <= (aw_addr[1:0] == 2'h0) ? RESP_OKAY :
				RESP_SLVERR;
		end else if (s_axi_bready_i) begin
			s_axi_bvalid_o <= 1'b0;
		end
	end

	// Control register; only byte lane 0 holds bits.
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			ctrl <= CTRL_RESET;
		end else if (do_write && aw_addr == ADDR_CTRL && w_strb[0]) begin
			ctrl <= w_data[CTRL_W-1:0];
		end
	end

	// Read data multiplexer.
	always_comb begin
		next_rdata = 32'h0;
		next_rresp = RESP_OKAY;
		unique case (s_axi_araddr_i)
			ADDR_CTRL:   next_rdata[CTRL_W-1:0] = ctrl;
			ADDR_STATUS: begin
				next_rdata[STAT_PERR]   = parity_mismatch_flag;
				next_rdata[STAT_RDPAR]  = read_parity;
				next_rdata[STAT_FORCE]  = force_bad;
				next_rdata[STAT_WREVEN] = write_even;
				next_rdata[STAT_STROBE] = write_strobe;
			end
			ADDR_INBUF:  next_rdata[DATA_W-1:0] = inbound_word_hold;
			ADDR_OUTBUF: next_rdata[DATA_W-1:0] = outbound_word_hold;
			default:     next_rresp = RESP_SLVERR;
		endcase
	end

	assign s_axi_arready_o = !s_axi_rvalid_o;

	// Read channel: answer one cycle after the address is taken.
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o  <= 32'h0;
			s_axi_rresp_o  <= RESP_OKAY;
		end else if (s_axi_arvalid_i && s_axi_arready_o) begin
			s_axi_rvalid_o <= 1'b1;
			s_axi_rdata_o  <= next_rdata;
			s_axi_rresp_o  <= next_rresp;
		end else if (s_axi_rready_i) begin
			s_axi_rvalid_o <= 1'b0;
		end
	end

endmodule

/* File: rtl/dwp_pkg.sv */
// Shared constants for the drum word parity datapath.
package dwp_pkg;

	// Word layout: 18 data bits plus one parity bit.
	localparam int DATA_W   = 18;
	localparam int WORD_W   = 19;
	localparam int PAR_POS  = 18;

	// Write strobe length, printed time and derived cycle count.
	localparam int CLK_MHZ        = 20;
	localparam int WR_STROBE_NS   = 2600;
	localparam int WR_STROBE_CYC  = (WR_STROBE_NS * CLK_MHZ) / 1000;
	localparam int STROBE_CNT_W   = 6;

	// Register byte offsets on the AXI4-Lite bus.
	localparam logic [3:0] ADDR_CTRL   = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h4;
	localparam logic [3:0] ADDR_INBUF  = 4'h8;
	localparam logic [3:0] ADDR_OUTBUF = 4'hc;

	// Control register fields.
	localparam int CTRL_ACTIVE    = 0;
	localparam int CTRL_WRITE     = 1;
	localparam int CTRL_READ      = 2;
	localparam int CTRL_WONLY     = 3;
	localparam int CTRL_W         = 4;
	localparam logic [3:0] CTRL_RESET = 4'h0;

	// Status register fields.
	localparam int STAT_PERR      = 0;
	localparam int STAT_RDPAR     = 1;
	localparam int STAT_FORCE     = 2;
	localparam int STAT_WREVEN    = 3;
	localparam int STAT_STROBE    = 4;

	// AXI response codes.
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* File: rtl/dwp_strobe_timer.sv */
// Write strobe timer: one strobe per qualified start pulse, fixed length unless the qualifier drops.
`timescale 1ns/1ps
module dwp_strobe_timer
	import dwp_pkg::*;
(
	// Clock and reset.
	input  wire logic mclk_i,
	input  wire logic reset_i,
	// Start request and qualifier.
	input  wire logic go_i,
	input  wire logic allow_i,
	// Strobe level.
	output logic      strobe_o
);

	typedef enum logic [1:0] {
		DWP_ST_IDLE   = 2'b01,
		DWP_ST_STROBE = 2'b10
	} dwp_strobe_e;

	dwp_strobe_e              state;
	logic [STROBE_CNT_W-1:0]  count;

	localparam logic [STROBE_CNT_W-1:0] LAST_CNT =
		STROBE_CNT_W'(WR_STROBE_CYC - 1);

	// The strobe starts on a qualified go and drops early if the drum
	// leaves write mode, so no writer current flows outside it.
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			state <= DWP_ST_IDLE;
			count <= '0;
		end else begin
			unique case (state)
				DWP_ST_IDLE: begin
					count <= '0;
					if (go_i && allow_i) begin
						state <= DWP_ST_STROBE;
					end
				end
				DWP_ST_STROBE: begin
					count <= count + 1'b1;
					if (!allow_i || count == LAST_CNT) begin
						state <= DWP_ST_IDLE;
					end
				end
			endcase
		end
	end

	assign strobe_o = (state == DWP_ST_STROBE) && allow_i;

endmodule

/* File: test/dwp_datapath_bench.sv */
// Self-checking bench for the drum word parity datapath.
`timescale 1ns/1ps
module dwp_datapath_bench;
	import dwp_pkg::*;
	logic              mclk_i, reset_i, btn, pclr, awv, wv, bro, arv, rr;
	logic [5:0]        tim;
	logic [WORD_W-1:0] sense, w1, w0;
	logic [DATA_W-1:0] bin, bout;
	logic              ack, wrs, rrs, we, flag, awr, wr, bv, arr, rv;
	logic [3:0]        aw_a, ar_a;
	logic [31:0]       w_d, rdata;
	logic [1:0]        bresp, rresp;
	int                n_mismatch = 0;
	int                n_compared = 0;
	dwp_datapath dwp_datapath_inst (
		.mclk_i(mclk_i), .reset_i(reset_i), .phase1_i(tim[0]),
		.phase2_i(tim[1]), .phase3_i(tim[2]), .phase4_i(tim[3]),
		.read_strobe_i(tim[4]), .write_go_i(tim[5]), .bus_in_i(bin),
		.addr_ack_i(ack), .write_restart_i(wrs), .read_restart_i(rrs),
		.bus_out_o(bout), .sense_i(sense), .bad_parity_button_i(btn),
		.power_clear_i(pclr), .writer_one_o(w1), .writer_zero_o(w0),
		.write_enable_o(we), .parity_mismatch_flag_o(flag),
		.s_axi_awaddr_i(aw_a), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
		.s_axi_wdata_i(w_d), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wv),
		.s_axi_wready_o(wr), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv),
		.s_axi_bready_i(bro), .s_axi_araddr_i(ar_a), .s_axi_arvalid_i(arv),
		.s_axi_arready_o(arr), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
		.s_axi_rvalid_o(rv), .s_axi_rready_i(rr)
	);
	dwp_mem_ctrl_model dwp_mem_ctrl_model_inst (
		.mclk_i(mclk_i), .bus_out_i(bout), .bus_in_o(bin),
		.addr_ack_o(ack), .write_restart_o(wrs), .read_restart_o(rrs)
	);
	// Compares a seen value with the expected one.
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		n_compared++;
		if (seen !== want) begin
			n_mismatch++;
			$display("BAD %0t seen %h want %h", $time, seen, want);
		end
	endtask
	// Prints the counts and the verdict, then stops.
	task automatic complete_run();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Ends the run when a handshake never answers.
	task automatic hang(input int k);
		if (k >= 100) begin
			n_mismatch++;
			$display("BAD %0t handshake timeout", $time);
			complete_run();
		end
	endtask
	// Pulses timing enables for one cycle.
	task automatic tick(input logic [5:0] v);
		@(posedge mclk_i);
		tim <= v;
		@(posedge mclk_i);
		tim <= '0;
	endtask
	// Register write with expected response.
	task automatic axw(input logic [3:0] a, input logic [31:0] d,
		input logic [1:0] want);
		int k;
		@(posedge mclk_i);
		aw_a <= a;
		w_d  <= d;
		awv  <= 1'b1;
		wv   <= 1'b1;
		bro  <= 1'b1;
		for (k = 0; k < 100; k++) begin
			@(posedge mclk_i);
			if (awr)
				awv <= 1'b0;
			if (wr)
				wv <= 1'b0;
			if (bv)
				break;
		end
		hang(k);
		bro <= 1'b0;
		check(bresp, want);
	endtask
	// Register read with expected data and response.
	task automatic axr(input logic [3:0] a, input logic [31:0] want,
		input logic [1:0] wresp);
		int k;
		@(posedge mclk_i);
		ar_a <= a;
		arv  <= 1'b1;
		rr   <= 1'b1;
		for (k = 0; k < 100; k++) begin
			@(posedge mclk_i);
			if (arr)
				arv <= 1'b0;
			if (rv)
				break;
		end
		hang(k);
		rr <= 1'b0;
		check(rdata, want);
		check(rresp, wresp);
	endtask
	// Starts a strobe on a word and checks the writer outputs.
	task automatic strobe_word(input logic [WORD_W-1:0] word);
		tick(6'h20);
		repeat (4) @(posedge mclk_i);
		check(w1, word);
		check(w0, WORD_W'(~word));
		check(we, 1'b1);
		repeat (60) @(posedge mclk_i);
		check(w1, 19'h00000);
	endtask
	// Normal, forced and restored parity on written words.
	task automatic t_write();
		axw(ADDR_CTRL, 32'h3, RESP_OKAY);
		dwp_mem_ctrl_model_inst.send_word(18'h00007, 3);
		strobe_word({1'b0, 18'h00007});
		@(posedge mclk_i);
		btn <= 1'b1;
		@(posedge mclk_i);
		btn <= 1'b0;
		dwp_mem_ctrl_model_inst.send_word(18'h00003, 6);
		strobe_word({1'b0, 18'h00003});
		dwp_mem_ctrl_model_inst.restart(1'b1);
		repeat (3) @(posedge mclk_i);
		strobe_word({1'b1, 18'h00003});
		btn <= 1'b1;
		@(posedge mclk_i);
		btn  <= 1'b0;
		pclr <= 1'b1;
		@(posedge mclk_i);
		pclr <= 1'b0;
		repeat (3) @(posedge mclk_i);
		axr(ADDR_STATUS, 32'h8, RESP_OKAY);
		$display("write test done");
	endtask
	// Write-only copy to the out buffer and clear on acknowledge.
	task automatic t_wonly();
		axw(ADDR_CTRL, 32'hb, RESP_OKAY);
		dwp_mem_ctrl_model_inst.send_word(18'h2a5a5, 3);
		tick(6'h01);
		tick(6'h04);
		repeat (2) @(posedge mclk_i);
		check(dwp_mem_ctrl_model_inst.returned, 18'h2a5a5);
		axr(ADDR_STATUS, 32'h0, RESP_OKAY);
		tick(6'h02);
		axr(ADDR_STATUS, 32'h8, RESP_OKAY);
		dwp_mem_ctrl_model_inst.send_word(18'h00001, 3);
		axr(ADDR_OUTBUF, 32'h0, RESP_OKAY);
		$display("write-only test done");
	endtask
	// Read parity, mismatch qualification and error flag.
	task automatic t_read();
		axw(ADDR_CTRL, 32'h5, RESP_OKAY);
		tick(6'h20);
		dwp_mem_ctrl_model_inst.restart(1'b0);
		@(posedge mclk_i);
		sense <= {1'b1, 18'h00001};
		repeat (3) @(posedge mclk_i);
		tick(6'h10);
		sense <= '0;
		tick(6'h08);
		@(posedge mclk_i);
		check(flag, 1'b1);
		axr(ADDR_OUTBUF, 32'h1, RESP_OKAY);
		axr(ADDR_STATUS, 32'h3, RESP_OKAY);
		axw(ADDR_STATUS, 32'h1, RESP_OKAY);
		axw(ADDR_CTRL, 32'hd, RESP_OKAY);
		tick(6'h08);
		@(posedge mclk_i);
		check(flag, 1'b0);
		axw(ADDR_CTRL, 32'h5, RESP_OKAY);
		dwp_mem_ctrl_model_inst.restart(1'b0);
		repeat (3) @(posedge mclk_i);
		tick(6'h08);
		@(posedge mclk_i);
		check(flag, 1'b0);
		dwp_mem_ctrl_model_inst.send_word(18'h00003, 3);
		tick(6'h08);
		@(posedge mclk_i);
		check(flag, 1'b1);
		axw(4'h2, 32'h0, RESP_SLVERR);
		axr(4'h2, 32'h0, RESP_SLVERR);
		$display("read test done");
	endtask
	// Free-running clock.
	initial begin
		mclk_i = 1'b0;
		forever #25 mclk_i = ~mclk_i;
	end
	// Reset, then the scenarios in turn.
	initial begin
		reset_i = 1'b1;
		{btn, pclr, awv, wv, bro, arv, rr} = '0;
		{tim, sense, aw_a, ar_a, w_d} = '0;
		repeat (4) @(posedge mclk_i);
		reset_i <= 1'b0;
		axr(ADDR_CTRL, 32'h0, RESP_OKAY);
		axr(ADDR_STATUS, 32'h8, RESP_OKAY);
		t_write();
		t_wonly();
		t_read();
		complete_run();
	end
endmodule

/* File: test/dwp_datapath_properties.sv */
// Port checker for the drum word parity datapath.
`timescale 1ns/1ps
module dwp_datapath_checker
	import dwp_pkg::*;
(
	// Observed ports.
	input wire logic              mclk_i,
	input wire logic              reset_i,
	input wire logic              phase3_i,
	input wire logic              phase4_i,
	input wire logic              write_go_i,
	input wire logic              bad_parity_button_i,
	input wire logic              power_clear_i,
	input wire logic              write_restart_i,
	input wire logic [DATA_W-1:0] bus_out_o,
	input wire logic [WORD_W-1:0] writer_one_o,
	input wire logic [WORD_W-1:0] writer_zero_o,
	input wire logic              write_enable_o,
	input wire logic              parity_mismatch_flag_o,
	input wire logic              s_axi_bvalid_o
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (reset_i);
	logic [6:0] run_len;
	logic [1:0] set_d;
	logic [1:0] clr_d;
	logic       forced_h;
	// Counts strobe cycles; the button and clear pins pass two stages as
	// in the block, so forced_h follows the forced parity state exactly.
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			run_len  <= 7'h00;
			set_d    <= 2'h0;
			clr_d    <= 2'h0;
			forced_h <= 1'b0;
		end else begin
			run_len <= (|writer_one_o) ? run_len + 7'h01 : 7'h00;
			set_d   <= {set_d[0], bad_parity_button_i};
			clr_d   <= {clr_d[0], write_restart_i || power_clear_i};
			if (set_d[1]) begin
				forced_h <= 1'b1;
			end else if (clr_d[1]) begin
				forced_h <= 1'b0;
			end
		end
	end
	sequence s_strobe_start;
		write_enable_o && $rose(|writer_one_o);
	endsequence
	property p_pair;
		write_enable_o |-> writer_zero_o == ~writer_one_o;
	endproperty
	property p_idle;
		!write_enable_o |-> writer_one_o == '0 && writer_zero_o == '0;
	endproperty
	property p_odd;
		write_enable_o && (|writer_one_o) |->
			(^writer_one_o) != $past(forced_h);
	endproperty
	property p_len;
		write_enable_o && !(|writer_one_o) && run_len != 7'h00
			|-> int'(run_len) == WR_STROBE_CYC;
	endproperty
	property p_go;
		s_strobe_start |-> $past(write_go_i, 2);
	endproperty
	property p_flag_p4;
		$rose(parity_mismatch_flag_o) |-> $past(phase4_i);
	endproperty
	property p_flag_hold;
		$fell(parity_mismatch_flag_o) |-> $rose(s_axi_bvalid_o);
	endproperty
	property p_out;
		(|bus_out_o) |-> $past(phase3_i);
	endproperty
	a_pair: assert property (p_pair) else $error("halves differ");
	a_idle: assert property (p_idle) else $error("writer idle");
	a_odd: assert property (p_odd) else $error("word parity");
	a_len: assert property (p_len) else $error("strobe length");
	a_go: assert property (p_go) else $error("strobe cause");
	a_flag_p4: assert property (p_flag_p4) else $error("flag time");
	a_flag_hold: assert property (p_flag_hold) else $error("flag drop");
	a_out: assert property (p_out) else $error("bus out time");
endmodule

bind dwp_datapath dwp_datapath_checker dwp_datapath_checker_inst (
	.mclk_i, .reset_i, .phase3_i, .phase4_i, .write_go_i,
	.bad_parity_button_i, .power_clear_i, .write_restart_i, .bus_out_o,
	.writer_one_o, .writer_zero_o, .write_enable_o,
	.parity_mismatch_flag_o, .s_axi_bvalid_o
);

/* File: test/dwp_mem_ctrl_model.sv */
// Memory control model at the far end of the pulsed bus transceiver.
`timescale 1ns/1ps
module dwp_mem_ctrl_model
	import dwp_pkg::*;
(
	// Clock and lines from the drum.
	input  wire logic              mclk_i,
	input  wire logic [DATA_W-1:0] bus_out_i,
	// Lines to the drum.
	output logic [DATA_W-1:0]      bus_in_o,
	output logic                   addr_ack_o,
	output logic                   write_restart_o,
	output logic                   read_restart_o
);
	logic [DATA_W-1:0] returned;
	// Keeps the last word pulsed back by the drum.
	always_ff @(posedge mclk_i) begin
		if (|bus_out_i)
			returned <= bus_out_i;
	end
	// Lines start quiet.
	initial begin
		bus_in_o        = '0;
		addr_ack_o      = 1'b0;
		write_restart_o = 1'b0;
		read_restart_o  = 1'b0;
	end
	// Sends a word with a one-cycle acknowledge, then drives its complement after hold cycles.
	task automatic send_word(input logic [DATA_W-1:0] w, input int hold);
		@(posedge mclk_i);
		bus_in_o   <= w;
		addr_ack_o <= 1'b1;
		@(posedge mclk_i);
		addr_ack_o <= 1'b0;
		repeat (hold) @(posedge mclk_i);
		bus_in_o <= ~w;
	endtask
	// Pulses one of the restart lines for one cycle.
	task automatic restart(input logic wr);
		@(posedge mclk_i);
		if (wr)
			write_restart_o <= 1'b1;
		else
			read_restart_o <= 1'b1;
		@(posedge mclk_i);
		write_restart_o <= 1'b0;
		read_restart_o  <= 1'b0;
	endtask
endmodule
